// ==== rrs_regs.vh ====
`ifndef RRS_REGS_VH
`define RRS_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RRS_OFS_INSTR        6'h00
`define RRS_OFS_WACC         6'h04
`define RRS_OFS_BANK         6'h08
`define RRS_OFS_STATUS       6'h0C
`define RRS_OFS_MEM_ADDR     6'h10
`define RRS_OFS_MEM_DATA     6'h14

// ----------------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------------
`define RRS_ST_CARRY         0
`define RRS_ST_ZERO          1
`define RRS_ST_NEG           2
`define RRS_ST_BUSY          3
`define RRS_ST_ILLEGAL       4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RRS_RST_INSTR        16'h0000
`define RRS_RST_WACC         8'h00
`define RRS_RST_BANK         4'h0
`define RRS_RST_MEM_ADDR     12'h000

// ----------------------------------------------------------------------------
// instruction word fields and opcodes
// ----------------------------------------------------------------------------
`define RRS_OP6_RRC          6'h0C
`define RRS_OP6_RRN          6'h10
`define RRS_OP7_SET          7'h34
`define RRS_BIT_DEST         9
`define RRS_BIT_ACCESS       8
`define RRS_ACC_SPLIT        8'h80
`define RRS_ACC_LOW_BANK     4'h0
`define RRS_ACC_HIGH_BANK    4'hF

// ----------------------------------------------------------------------------
// alu operation codes
// ----------------------------------------------------------------------------
`define RRS_ALU_RRC          2'h0
`define RRS_ALU_RRN          2'h1
`define RRS_ALU_SET          2'h2

// ----------------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------------
`define RRS_RESP_OKAY        2'h0
`define RRS_RESP_SLVERR      2'h2

`endif

// ==== rrs_alu.v ====
`timescale 1ns/1ps
`include "rrs_regs.vh"

module rrs_alu (
  input  wire [1:0] op_in,
  input  wire [7:0] operand_in,
  input  wire       carry_in,
  output reg  [7:0] result_out,
  output reg        carry_out
);

  // --------------------------------------------------------------------------
  // rotate and fill
  // --------------------------------------------------------------------------
  always @* begin
    result_out = operand_in;
    carry_out  = carry_in;
    case (op_in)
      `RRS_ALU_RRC: begin
        result_out = {carry_in, operand_in[7:1]};   // RL1
        carry_out  = operand_in[0];                 // RL1
      end
      `RRS_ALU_RRN: begin
        result_out = {operand_in[0], operand_in[7:1]}; // RL6
      end
      `RRS_ALU_SET: begin
        result_out = 8'hFF;
      end
      default: begin
        result_out = operand_in;
      end
    endcase
  end

endmodule // rrs_alu

// ==== rrs_axil_slave.v ====
`timescale 1ns/1ps
`include "rrs_regs.vh"

module rrs_axil_slave (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [5:0]  awaddr_in,
  input  wire        awvalid_in,
  output reg         awready_out,
  input  wire [31:0] wdata_in,
  input  wire [3:0]  wstrb_in,
  input  wire        wvalid_in,
  output reg         wready_out,
  output reg  [1:0]  bresp_out,
  output reg         bvalid_out,
  input  wire        bready_in,
  input  wire [5:0]  araddr_in,
  input  wire        arvalid_in,
  output reg         arready_out,
  output reg  [31:0] rdata_out,
  output reg  [1:0]  rresp_out,
  output reg         rvalid_out,
  input  wire        rready_in,
  output wire        wr_en_out,
  output wire [5:0]  wr_addr_out,
  output wire [31:0] wr_data_out,
  output wire [3:0]  wr_strb_out,
  input  wire        wr_ok_in,
  output wire [5:0]  rd_addr_out,
  input  wire [31:0] rd_data_in,
  input  wire        rd_ok_in
);

  reg        aw_full_reg;
  reg        w_full_reg;
  reg [5:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  wire       aw_take;
  wire       w_take;
  wire       ar_take;

  assign aw_take     = awvalid_in & awready_out;
  assign w_take      = wvalid_in & wready_out;
  assign ar_take     = arvalid_in & arready_out;
  assign wr_en_out   = aw_full_reg & w_full_reg & ~bvalid_out;
  assign wr_addr_out = aw_addr_reg;
  assign wr_data_out = w_data_reg;
  assign wr_strb_out = w_strb_reg;
  assign rd_addr_out = araddr_in;

  // --------------------------------------------------------------------------
  // write channels: address and data held until both present
  // --------------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      awready_out <= 1'b0;
      wready_out  <= 1'b0;
      bvalid_out  <= 1'b0;
      bresp_out   <= `RRS_RESP_OKAY;
    end else begin
      awready_out <= ~aw_full_reg & ~aw_take & ~bvalid_out;
      wready_out  <= ~w_full_reg & ~w_take & ~bvalid_out;
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr_in;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata_in;
        w_strb_reg <= wstrb_in;
      end
      if (wr_en_out) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_out  <= 1'b1;
        bresp_out   <= wr_ok_in ? `RRS_RESP_OKAY : `RRS_RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h00000000;
      rresp_out   <= `RRS_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_out <= 1'b0;
        rvalid_out  <= 1'b1;
        rdata_out   <= rd_ok_in ? rd_data_in : 32'h00000000;
        rresp_out   <= rd_ok_in ? `RRS_RESP_OKAY : `RRS_RESP_SLVERR;
      end else if (rvalid_out) begin
        if (rready_in) begin
          rvalid_out  <= 1'b0;
          arready_out <= 1'b1;
        end
      end else begin
        arready_out <= 1'b1;
      end
    end
  end

endmodule // rrs_axil_slave

// ==== rrs_exec.v ====
// Behaviour
// [RL1] rotate right through carry, carry into bit7
// [RL2] destination bit 0 writes working accumulator
// [RL3] destination bit 1 writes file register back
// [RL4] access bit 0 selects access bank
// [RL5] access bit 1 uses bank pointer
// [RL6] rotate right plain, carry untouched
// [RL7] one cycle, four phases, N Z update
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rrs_regs.vh"

module rrs_exec #(
  parameter BANK_W = 4,
  parameter MEM_DEPTH = 4096
) (
  input  wire        CLK_IN,
  input  wire        RST_N_IN,
  input  wire [5:0]  AXI_AWADDR_IN,
  input  wire        AXI_AWVALID_IN,
  output wire        AXI_AWREADY_OUT,
  input  wire [31:0] AXI_WDATA_IN,
  input  wire [3:0]  AXI_WSTRB_IN,
  input  wire        AXI_WVALID_IN,
  output wire        AXI_WREADY_OUT,
  output wire [1:0]  AXI_BRESP_OUT,
  output wire        AXI_BVALID_OUT,
  input  wire        AXI_BREADY_IN,
  input  wire [5:0]  AXI_ARADDR_IN,
  input  wire        AXI_ARVALID_IN,
  output wire        AXI_ARREADY_OUT,
  output wire [31:0] AXI_RDATA_OUT,
  output wire [1:0]  AXI_RRESP_OUT,
  output wire        AXI_RVALID_OUT,
  input  wire        AXI_RREADY_IN
);

  // --------------------------------------------------------------------------
  // phase states
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_Q1   = 5'h02;
  localparam [4:0] ST_Q2   = 5'h04;
  localparam [4:0] ST_Q3   = 5'h08;
  localparam [4:0] ST_Q4   = 5'h10;
  localparam       ADDR_W  = BANK_W + 8;

  reg  [7:0]        mem [0:MEM_DEPTH-1];
  reg  [4:0]        state_reg;
  reg  [4:0]        state_next;
  reg  [15:0]       instr_reg;
  reg  [7:0]        wacc_reg;
  reg  [BANK_W-1:0] bank_reg;
  reg               carry_reg;
  reg               zero_reg;
  reg               neg_reg;
  reg               illegal_reg;
  reg  [ADDR_W-1:0] mem_addr_reg;
  reg  [ADDR_W-1:0] op_addr_reg;
  reg  [7:0]        operand_reg;
  reg  [7:0]        result_reg;
  reg               carry_res_reg;
  reg  [1:0]        alu_op_reg;
  reg               legal_dec;
  reg  [1:0]        alu_op_dec;
  reg  [ADDR_W-1:0] addr_dec;
  reg  [31:0]       rd_data;
  reg               rd_ok;
  reg               wr_ok;
  wire              wr_en;
  wire [5:0]        wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;
  wire [5:0]        rd_addr;
  wire [7:0]        alu_result;
  wire              alu_carry;
  wire              busy;
  wire              start;
  wire              dest_file;
  wire              is_set;
  wire              sw_mem_wr;

  assign busy      = ~state_reg[0];
  assign start     = wr_en && (wr_addr == `RRS_OFS_INSTR) && !busy;
  assign dest_file = instr_reg[`RRS_BIT_DEST];
  assign is_set    = (alu_op_reg == `RRS_ALU_SET);
  assign sw_mem_wr = wr_en && (wr_addr == `RRS_OFS_MEM_DATA) && wr_strb[0] && !busy;

  // --------------------------------------------------------------------------
  // bus slave and alu
  // --------------------------------------------------------------------------
  rrs_axil_slave u_bus (
    .clk_in      (CLK_IN),
    .rst_n_in    (RST_N_IN),
    .awaddr_in   (AXI_AWADDR_IN),
    .awvalid_in  (AXI_AWVALID_IN),
    .awready_out (AXI_AWREADY_OUT),
    .wdata_in    (AXI_WDATA_IN),
    .wstrb_in    (AXI_WSTRB_IN),
    .wvalid_in   (AXI_WVALID_IN),
    .wready_out  (AXI_WREADY_OUT),
    .bresp_out   (AXI_BRESP_OUT),
    .bvalid_out  (AXI_BVALID_OUT),
    .bready_in   (AXI_BREADY_IN),
    .araddr_in   (AXI_ARADDR_IN),
    .arvalid_in  (AXI_ARVALID_IN),
    .arready_out (AXI_ARREADY_OUT),
    .rdata_out   (AXI_RDATA_OUT),
    .rresp_out   (AXI_RRESP_OUT),
    .rvalid_out  (AXI_RVALID_OUT),
    .rready_in   (AXI_RREADY_IN),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_ok_in    (wr_ok),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_data),
    .rd_ok_in    (rd_ok)
  );

  rrs_alu u_alu (
    .op_in      (alu_op_reg),
    .operand_in (operand_reg),
    .carry_in   (carry_reg),
    .result_out (alu_result),
    .carry_out  (alu_carry)
  );

  // --------------------------------------------------------------------------
  // instruction decode and operand address
  // --------------------------------------------------------------------------
  always @* begin
    legal_dec  = 1'b1;
    alu_op_dec = `RRS_ALU_RRC;
    if (instr_reg[15:10] == `RRS_OP6_RRC) begin
      alu_op_dec = `RRS_ALU_RRC;
    end else if (instr_reg[15:10] == `RRS_OP6_RRN) begin
      alu_op_dec = `RRS_ALU_RRN;
    end else if (instr_reg[15:9] == `RRS_OP7_SET) begin
      alu_op_dec = `RRS_ALU_SET;
    end else begin
      legal_dec  = 1'b0;
    end
    if (instr_reg[`RRS_BIT_ACCESS]) begin
      addr_dec = {bank_reg, instr_reg[7:0]};                                        // RL5
    end else if (instr_reg[7:0] < `RRS_ACC_SPLIT) begin
      addr_dec = {{(BANK_W-4){1'b0}}, `RRS_ACC_LOW_BANK, instr_reg[7:0]};          // RL4
    end else begin
      addr_dec = {{(BANK_W-4){1'b0}}, `RRS_ACC_HIGH_BANK, instr_reg[7:0]};         // RL4
    end
  end

  // --------------------------------------------------------------------------
  // phase sequencer
  // --------------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_Q1;
        end
      end
      ST_Q1: begin
        state_next = legal_dec ? ST_Q2 : ST_IDLE;
      end
      ST_Q2: begin
        state_next = ST_Q3;
      end
      ST_Q3: begin
        state_next = ST_Q4;
      end
      ST_Q4: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next; // RL7
    end
  end

  // --------------------------------------------------------------------------
  // datapath through the four phases
  // --------------------------------------------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      alu_op_reg    <= `RRS_ALU_RRC;
      op_addr_reg   <= {ADDR_W{1'b0}};
      operand_reg   <= 8'h00;
      result_reg    <= 8'h00;
      carry_res_reg <= 1'b0;
    end else begin
      if (state_reg == ST_Q1) begin
        alu_op_reg  <= alu_op_dec;
        op_addr_reg <= addr_dec;
      end
      if (state_reg == ST_Q2) begin
        operand_reg <= mem[op_addr_reg];
      end
      if (state_reg == ST_Q3) begin
        result_reg    <= alu_result;
        carry_res_reg <= alu_carry;
      end
    end
  end

  // --------------------------------------------------------------------------
  // data memory write port
  // --------------------------------------------------------------------------
  always @(posedge CLK_IN) begin
    if (state_reg == ST_Q4 && (dest_file || is_set)) begin
      mem[op_addr_reg] <= result_reg; // RL3
    end else if (sw_mem_wr) begin
      mem[mem_addr_reg] <= wr_data[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // software visible registers and flags
  // --------------------------------------------------------------------------
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      instr_reg    <= `RRS_RST_INSTR;
      wacc_reg     <= `RRS_RST_WACC;
      bank_reg     <= {BANK_W{1'b0}};
      mem_addr_reg <= {ADDR_W{1'b0}};
      carry_reg    <= 1'b0;
      zero_reg     <= 1'b0;
      neg_reg      <= 1'b0;
      illegal_reg  <= 1'b0;
    end else begin
      if (wr_en && !busy) begin
        case (wr_addr)
          `RRS_OFS_INSTR: begin
            if (wr_strb[0]) instr_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1]) instr_reg[15:8] <= wr_data[15:8];
          end
          `RRS_OFS_WACC: begin
            if (wr_strb[0]) wacc_reg <= wr_data[7:0];
          end
          `RRS_OFS_BANK: begin
            if (wr_strb[0]) bank_reg <= wr_data[BANK_W-1:0];
          end
          `RRS_OFS_STATUS: begin
            if (wr_strb[0]) begin
              carry_reg   <= wr_data[`RRS_ST_CARRY];
              zero_reg    <= wr_data[`RRS_ST_ZERO];
              neg_reg     <= wr_data[`RRS_ST_NEG];
              illegal_reg <= wr_data[`RRS_ST_ILLEGAL];
            end
          end
          `RRS_OFS_MEM_ADDR: begin
            if (wr_strb[0]) mem_addr_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1]) mem_addr_reg[ADDR_W-1:8] <= wr_data[ADDR_W-1:8];
          end
          default: begin
            mem_addr_reg <= mem_addr_reg;
          end
        endcase
      end
      if (state_reg == ST_Q1 && !legal_dec) begin
        illegal_reg <= 1'b1;
      end
      if (state_reg == ST_Q4) begin
        if (!dest_file && !is_set) begin
          wacc_reg <= result_reg; // RL2
        end
        if (!is_set) begin
          zero_reg <= (result_reg == 8'h00); // RL7
          neg_reg  <= result_reg[7];         // RL7
        end
        if (alu_op_reg == `RRS_ALU_RRC) begin
          carry_reg <= carry_res_reg; // RL1
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // read mux and decode answers
  // --------------------------------------------------------------------------
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      `RRS_OFS_INSTR: begin
        rd_data[15:0] = instr_reg;
      end
      `RRS_OFS_WACC: begin
        rd_data[7:0] = wacc_reg;
      end
      `RRS_OFS_BANK: begin
        rd_data[BANK_W-1:0] = bank_reg;
      end
      `RRS_OFS_STATUS: begin
        rd_data[`RRS_ST_CARRY]   = carry_reg;
        rd_data[`RRS_ST_ZERO]    = zero_reg;
        rd_data[`RRS_ST_NEG]     = neg_reg;
        rd_data[`RRS_ST_BUSY]    = busy;
        rd_data[`RRS_ST_ILLEGAL] = illegal_reg;
      end
      `RRS_OFS_MEM_ADDR: begin
        rd_data[ADDR_W-1:0] = mem_addr_reg;
      end
      `RRS_OFS_MEM_DATA: begin
        rd_data[7:0] = mem[mem_addr_reg];
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always @* begin
    case (wr_addr)
      `RRS_OFS_INSTR, `RRS_OFS_WACC, `RRS_OFS_BANK,
      `RRS_OFS_STATUS, `RRS_OFS_MEM_ADDR, `RRS_OFS_MEM_DATA: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

endmodule // rrs_exec

// ==== rrs_exec_sva.sv ====
`timescale 1ns/1ps
`include "rrs_regs.vh"

module rrs_exec_sva #(
  parameter BANK_W    = 4,
  parameter MEM_DEPTH = 4096
) (
  input wire        CLK_IN,
  input wire        RST_N_IN,
  input wire [5:0]  AXI_AWADDR_IN,
  input wire        AXI_AWVALID_IN,
  input wire        AXI_AWREADY_OUT,
  input wire        AXI_WVALID_IN,
  input wire        AXI_WREADY_OUT,
  input wire [1:0]  AXI_BRESP_OUT,
  input wire        AXI_BVALID_OUT,
  input wire        AXI_BREADY_IN,
  input wire [5:0]  AXI_ARADDR_IN,
  input wire        AXI_ARVALID_IN,
  input wire        AXI_ARREADY_OUT,
  input wire [31:0] AXI_RDATA_OUT,
  input wire [1:0]  AXI_RRESP_OUT,
  input wire        AXI_RVALID_OUT,
  input wire        AXI_RREADY_IN
);
  // --------------------------------------------------------------------------
  // register bus handshakes
  // --------------------------------------------------------------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_b_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
    else $error("write response dropped before taken");
  a_r_hold: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
    AXI_RVALID_OUT && $stable(AXI_RDATA_OUT) && $stable(AXI_RRESP_OUT))
    else $error("read response changed before taken");
  a_r_answer: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
    else $error("read answer late");
  a_b_answer: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT
    |-> ##[1:2] AXI_BVALID_OUT)
    else $error("write answer late");
  a_wr_block: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write accepted while response pending");
  a_b_clear: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT)
    else $error("write response repeated");
  a_bad_read: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT && AXI_ARADDR_IN > `RRS_OFS_MEM_DATA
    |=> AXI_RRESP_OUT == `RRS_RESP_SLVERR && AXI_RDATA_OUT == 32'h0)
    else $error("unmapped read not refused");
  a_bad_write: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_AWADDR_IN > `RRS_OFS_MEM_DATA
    |-> ##[1:3] AXI_BVALID_OUT && AXI_BRESP_OUT == `RRS_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_ok_read: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT && AXI_ARADDR_IN <= `RRS_OFS_MEM_DATA
    && AXI_ARADDR_IN[1:0] == 2'h0 |=> AXI_RRESP_OUT == `RRS_RESP_OKAY)
    else $error("mapped read refused");
endmodule // rrs_exec_sva

bind rrs_exec rrs_exec_sva #(.BANK_W(BANK_W), .MEM_DEPTH(MEM_DEPTH)) rrs_exec_sva_inst (
  .CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN),
  .AXI_AWADDR_IN(AXI_AWADDR_IN),
  .AXI_AWVALID_IN(AXI_AWVALID_IN),
  .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
  .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT),
  .AXI_BRESP_OUT(AXI_BRESP_OUT),
  .AXI_BVALID_OUT(AXI_BVALID_OUT),
  .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARADDR_IN(AXI_ARADDR_IN),
  .AXI_ARVALID_IN(AXI_ARVALID_IN),
  .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
  .AXI_RDATA_OUT(AXI_RDATA_OUT),
  .AXI_RRESP_OUT(AXI_RRESP_OUT),
  .AXI_RVALID_OUT(AXI_RVALID_OUT),
  .AXI_RREADY_IN(AXI_RREADY_IN)
);

// ==== rotate_right_set_exec_bench.sv ====
`timescale 1ns/1ps
`include "rrs_regs.vh"

module rotate_right_set_exec_bench;
  reg          clk;
  reg          rst_n;
  reg  [5:0]   awaddr;
  reg          awvalid;
  wire         awready;
  reg  [31:0]  wdata;
  reg          wvalid;
  wire         wready;
  wire [1:0]   bresp;
  wire         bvalid;
  reg          bready;
  reg  [5:0]   araddr;
  reg          arvalid;
  wire         arready;
  wire [31:0]  rdata;
  wire [1:0]   rresp;
  wire         rvalid;
  reg          rready;
  integer      error_cnt;
  integer      n_tests;
  logic [31:0] rd;
  logic [1:0]  rsp;

  rrs_exec #(.BANK_W(4), .MEM_DEPTH(4096)) rrs_exec_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready)
  );

  // --------------------------------------------------------------------------
  // bus master and helpers
  // --------------------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bit got;
    begin
      got = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      while (!got) begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'h0;
        if (wvalid && wready) wvalid <= 1'h0;
        if (bvalid && bready) begin
          rsp = bresp;
          got = 1;
          bready <= 1'h0;
        end
      end
    end
  endtask

  task automatic rdr(input logic [5:0] a);
    bit got;
    begin
      got = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!got) begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'h0;
        if (rvalid && rready) begin
          rd  = rdata;
          rsp = rresp;
          got = 1;
          rready <= 1'h0;
        end
      end
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        $display("mismatch %s expected %h seen %h", nm, e, g);
        error_cnt = error_cnt + 1;
      end
    end
  endtask

  task automatic exec(input logic [15:0] ins);
    integer i;
    begin
      wr(`RRS_OFS_INSTR, {16'h0, ins});
      rdr(`RRS_OFS_STATUS);
      for (i = 0; i < 20 && rd[`RRS_ST_BUSY] !== 1'h0; i++) rdr(`RRS_OFS_STATUS);
      chk("busy", 32'h0, {31'h0, rd[`RRS_ST_BUSY]});
    end
  endtask

  task automatic memw(input logic [11:0] a, input logic [7:0] d);
    begin
      wr(`RRS_OFS_MEM_ADDR, {20'h0, a});
      wr(`RRS_OFS_MEM_DATA, {24'h0, d});
    end
  endtask

  task automatic memc(input logic [11:0] a, input logic [7:0] e);
    begin
      wr(`RRS_OFS_MEM_ADDR, {20'h0, a});
      rdr(`RRS_OFS_MEM_DATA);
      chk("mem", {24'h0, e}, rd);
    end
  endtask

  // flags are {negative, zero, carry}
  task automatic flg(input logic [2:0] e);
    begin
      rdr(`RRS_OFS_STATUS);
      chk("flags", {29'h0, e}, {29'h0, rd[2:0]});
    end
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    begin
      rdr(`RRS_OFS_INSTR);
      chk("instr", 32'h0, rd);
      rdr(`RRS_OFS_BANK);
      chk("bank", 32'h0, rd);
      rdr(`RRS_OFS_MEM_ADDR);
      chk("mem_addr", 32'h0, rd);
      rdr(`RRS_OFS_WACC);
      chk("wacc", 32'h0, rd);
      rdr(`RRS_OFS_STATUS);
      chk("status", 32'h0, rd);
      rdr(6'h3C);
      chk("bad_rd", {30'h0, `RRS_RESP_SLVERR}, {30'h0, rsp});
      wr(6'h3C, 32'h5A);
      chk("bad_wr", {30'h0, `RRS_RESP_SLVERR}, {30'h0, rsp});
    end
  endtask

  task automatic t_rrc;
    begin
      memw(12'h020, 8'hE6);
      wr(`RRS_OFS_STATUS, 32'h0);
      exec(16'h3020);
      rdr(`RRS_OFS_WACC);
      chk("wacc", 32'h73, rd);
      memc(12'h020, 8'hE6);
      flg(3'h0);
      wr(`RRS_OFS_STATUS, 32'h1);
      exec(16'h3220);
      memc(12'h020, 8'hF3);
      flg(3'h4);
      memw(12'h021, 8'h01);
      wr(`RRS_OFS_STATUS, 32'h0);
      exec(16'h3221);
      memc(12'h021, 8'h00);
      flg(3'h3);
      rdr(`RRS_OFS_WACC);
      chk("wacc", 32'h73, rd);
    end
  endtask

  task automatic t_rrn;
    begin
      wr(`RRS_OFS_BANK, 32'h5);
      memw(12'h540, 8'hD7);
      memw(12'h040, 8'h00);
      wr(`RRS_OFS_STATUS, 32'h1);
      exec(16'h4340);
      memc(12'h540, 8'hEB);
      memc(12'h040, 8'h00);
      flg(3'h5);
      memw(12'hF90, 8'h02);
      exec(16'h4090);
      rdr(`RRS_OFS_WACC);
      chk("wacc", 32'h01, rd);
      memc(12'hF90, 8'h02);
      flg(3'h1);
    end
  endtask

  task automatic t_set;
    begin
      memw(12'h010, 8'h5A);
      memw(12'h510, 8'h00);
      wr(`RRS_OFS_STATUS, 32'h2);
      exec(16'h6810);
      memc(12'h010, 8'hFF);
      memc(12'h510, 8'h00);
      flg(3'h2);
      exec(16'h6910);
      memc(12'h510, 8'hFF);
    end
  endtask

  // undecoded opcode is refused, and a write landing in the final phase is ignored
  task automatic t_bad;
    begin
      memw(12'h030, 8'h81);
      exec(16'h4430);
      rdr(`RRS_OFS_STATUS);
      chk("illegal", 32'h1, {31'h0, rd[`RRS_ST_ILLEGAL]});
      memc(12'h030, 8'h81);
      wr(`RRS_OFS_STATUS, 32'h0);
      wr(`RRS_OFS_INSTR, 32'h3230);
      wr(`RRS_OFS_WACC, 32'h55);
      chk("busy_wr", {30'h0, `RRS_RESP_OKAY}, {30'h0, rsp});
      rdr(`RRS_OFS_WACC);
      chk("wacc", 32'h01, rd);
      memc(12'h030, 8'h40);
      flg(3'h1);
    end
  endtask

  // --------------------------------------------------------------------------
  // clock, sequence, watchdog
  // --------------------------------------------------------------------------
  task report_and_stop;
    begin
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    error_cnt = 0;
    n_tests   = 0;
    rst_n     = 1'h0;
    awaddr    = 6'h0;
    awvalid   = 1'h0;
    wdata     = 32'h0;
    wvalid    = 1'h0;
    bready    = 1'h0;
    araddr    = 6'h0;
    arvalid   = 1'h0;
    rready    = 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_rrc;
    t_rrn;
    t_set;
    t_bad;
    report_and_stop;
  end

  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
endmodule // rotate_right_set_exec_bench
